// file: design/irq_unit_pkg.sv
// shared constants and types of the multi-level interrupt unit
package irq_unit_pkg;
  // clocks per machine cycle; the unit polls once per machine cycle
  localparam int          MC_CLKS      = 12;
  // response window, machine cycles, exclusive bounds
  localparam int          LAT_MIN_MC   = 3;
  localparam int          LAT_MAX_MC   = 9;
  localparam int          NUM_PAIRS    = 6;
  localparam int          NUM_SRC      = 12;
  localparam int          NUM_CMP      = 4;
  // special-register addresses of the enable and priority registers
  localparam logic [7:0]  ADDR_EN_LO   = 8'ha8;
  localparam logic [7:0]  ADDR_EN_HI   = 8'hb8;
  localparam logic [7:0]  ADDR_PRIO_LO = 8'ha9;
  localparam logic [7:0]  ADDR_PRIO_HI = 8'hb9;
  localparam logic [7:0]  RST_REG      = 8'h00;
  // global enable position in the low enable register
  localparam int          EN_ALL_BIT   = 7;
  // writable width of the high priority register
  localparam int          PRIO_HI_W    = 6;
  // vector addresses: member 0 of a pair, member 1, step per pair
  localparam logic [15:0] VEC_BASE_LO  = 16'h0003;
  localparam logic [15:0] VEC_BASE_HI  = 16'h0043;
  localparam logic [15:0] VEC_STEP     = 16'h0008;
  localparam logic [15:0] VEC_SERIAL   = 16'h0023;
  localparam logic [15:0] VEC_TIMER2   = 16'h002b;

  // compare output behaviour of one channel
  typedef enum logic {
    CMP_SET_ON_MATCH = 1'b0,
    CMP_SOFT_LEVEL   = 1'b1
  } cmp_mode_e;

  // configuration of one compare channel
  typedef struct packed {
    logic        enable;
    cmp_mode_e   mode;
    logic        soft_level;
    logic [15:0] value;
  } cmp_cfg_s;

  // request presented to the cpu core
  typedef struct packed {
    logic        valid;
    logic [1:0]  level;
    logic [15:0] vector;
  } irq_req_s;
endpackage

// file: design/multi_level_interrupt_unit.sv
// twelve-vector, four-level interrupt unit with timer 2 compare logic
//
// Overview of operation
// - twelve vectors, fixed addresses, eight-byte steps
// - serial and timer 2 vectors have two causes
// - each vector has its own enable
// - response between 3 and 9 machine cycles
// - ext 0/1 trigger on low level or fall
// - ext 2/3 trigger on chosen edge
// - ext 3..6 share pins with compare/capture
// - vector pairs take one of four levels
// - compare match drives output, raises request
// - mode 0: match sets, overflow clears output
// - mode 1: software level, overflow no change
// - port 1 bits carry ext 2..6 and channels
// - port 3 bits carry ext 0 and 1
// - reload trigger pin sets reload flag
// - enable/priority registers reset to zero
`timescale 1ns/1ps
module multi_level_interrupt_unit #(
  parameter int MC_CLKS = irq_unit_pkg::MC_CLKS
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ext_irq_pin_0,
  input  wire logic                        ext_irq_pin_1,
  input  wire logic                        ext_irq_pin_2,
  input  wire logic [3:0]                  cmp_cap_pin_in,
  input  wire logic                        timer2_reload_trigger_pin,
  output logic [3:0]                       cmp_cap_pin_out,
  output logic [3:0]                       cmp_cap_pin_oe_n,
  input  wire logic                        reg_wr_en,
  input  wire logic [7:0]                  reg_wr_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic [1:0]                  ext01_edge_mode,
  input  wire logic [1:0]                  ext23_rising,
  input  wire irq_unit_pkg::cmp_cfg_s [3:0] cmp_cfg,
  input  wire logic [15:0]                 timer2_count,
  input  wire logic                        timer2_ovf_pulse,
  input  wire logic                        timer0_overflow_flag,
  input  wire logic                        timer1_overflow_flag,
  input  wire logic                        uart_receive_done,
  input  wire logic                        uart_transmit_done,
  input  wire logic                        timer2_overflow_flag,
  input  wire logic                        converter_done_flag,
  input  wire logic                        reload_flag_clr,
  input  wire logic                        cpu_ack,
  input  wire logic                        cpu_reti,
  output irq_unit_pkg::irq_req_s           irq_req,
  output logic [11:0]                      taken_src,
  output logic [3:0]                       in_service,
  output logic [6:0]                       ext_irq_flags,
  output logic                             timer2_reload_pin_flag,
  output logic [7:0]                       irq_enable_reg_lo,
  output logic [7:0]                       irq_enable_reg_hi,
  output logic [7:0]                       prio_level_reg_lo,
  output logic [7:0]                       prio_level_reg_hi
);
  localparam int CW = $clog2(MC_CLKS);
  localparam int req_bound = 2 * MC_CLKS;

  // the divider needs at least two clocks per machine cycle
  if (MC_CLKS < 2 || MC_CLKS > 255) begin : g_chk
    $error("MC_CLKS out of range");
  end

  logic [CW-1:0] mc_cnt;      // position inside the machine cycle
  logic          mc_en;       // one pulse per machine cycle
  logic [7:0]    sync1;       // first synchroniser stage
  logic [7:0]    sync2;       // second synchroniser stage
  logic [7:0]    pin_q;       // pin level sampled per machine cycle
  logic [7:0]    pin_prev;    // level one machine cycle earlier
  logic [7:0]    fall;        // falling transition seen
  logic [7:0]    rise;        // rising transition seen
  logic [3:0]    cmp_hit;     // compare match, first cycle only
  logic [3:0]    match_q;     // match seen last cycle
  logic [11:0]   pend;        // raw requests, index 2*pair+member
  logic [11:0]   en_vec;      // per-vector enables
  logic [11:0]   clr;         // source taken this cycle
  logic [3:0]    req_idx;     // source of the presented request
  logic          win_valid;   // a request may be presented
  logic [3:0]    win_idx;     // winning source
  logic [1:0]    win_lvl;     // its level
  logic [1:0]    top_lvl;     // highest level in service
  logic          take;        // cpu takes the presented request

  assign take = cpu_ack && irq_req.valid;

  // machine cycle divider
  always_ff @(posedge clk) begin
    if (rst || mc_cnt == CW'(MC_CLKS - 1)) begin
      mc_cnt <= '0;
    end else begin
      mc_cnt <= mc_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    mc_en <= !rst && mc_cnt == CW'(MC_CLKS - 1);
  end

  // pins are idle high, so synchronisers reset high
  // ext 0..2, compare/capture and reload pins
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1 <= 8'hff;
      sync2 <= 8'hff;
    end else begin
      sync1 <= {timer2_reload_trigger_pin, cmp_cap_pin_in,
                ext_irq_pin_2, ext_irq_pin_1, ext_irq_pin_0};
      sync2 <= sync1;
    end
  end

  // sample once per machine cycle; an edge needs two samples
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q    <= 8'hff;
      pin_prev <= 8'hff;
    end else if (mc_en) begin
      pin_q    <= sync2;
      pin_prev <= pin_q;
    end
  end

  assign fall = pin_prev & ~pin_q;
  assign rise = ~pin_prev & pin_q;

  // software register writes; addresses not listed are ignored
  // reset to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enable_reg_lo <= irq_unit_pkg::RST_REG;
      irq_enable_reg_hi <= irq_unit_pkg::RST_REG;
      prio_level_reg_lo <= irq_unit_pkg::RST_REG;
      prio_level_reg_hi <= irq_unit_pkg::RST_REG;
    end else if (reg_wr_en) begin
      unique case (reg_wr_addr)
        irq_unit_pkg::ADDR_EN_LO:   irq_enable_reg_lo <= reg_wdata;
        irq_unit_pkg::ADDR_EN_HI:   irq_enable_reg_hi <= reg_wdata;
        irq_unit_pkg::ADDR_PRIO_LO: prio_level_reg_lo <= reg_wdata;
        // top two bits are undefined; they read as zero here
        irq_unit_pkg::ADDR_PRIO_HI: prio_level_reg_hi <=
          {2'b00, reg_wdata[irq_unit_pkg::PRIO_HI_W-1:0]};
        default: ;
      endcase
    end
  end

  // compare channels; output drive enable is low in compare mode
  for (genvar c = 0; c < irq_unit_pkg::NUM_CMP; c++) begin : g_cmp
    logic hit;
    assign hit        = cmp_cfg[c].enable &&
                        timer2_count == cmp_cfg[c].value;
    assign cmp_hit[c] = hit && !match_q[c];

    always_ff @(posedge clk) begin
      match_q[c] <= !rst && hit;
    end

    always_ff @(posedge clk) begin
      cmp_cap_pin_oe_n[c] <= rst || !cmp_cfg[c].enable;
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        cmp_cap_pin_out[c] <= 1'b0;
      end else if (cmp_cfg[c].mode == irq_unit_pkg::CMP_SET_ON_MATCH) begin
        if (cmp_hit[c]) begin
          cmp_cap_pin_out[c] <= 1'b1;
        end else if (timer2_ovf_pulse) begin
          cmp_cap_pin_out[c] <= 1'b0;
        end
      end else if (cmp_hit[c]) begin
        cmp_cap_pin_out[c] <= cmp_cfg[c].soft_level;
      end
    end
  end

  // external flags; a set in the clearing cycle wins
  // ack clears, level follows
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_irq_flags <= 7'h00;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (!ext01_edge_mode[k]) begin
          if (mc_en) ext_irq_flags[k] <= !pin_q[k];
        end else if (mc_en && fall[k]) begin
          ext_irq_flags[k] <= 1'b1;
        end else if (clr[4*k]) begin
          ext_irq_flags[k] <= 1'b0;
        end
      end
      // ext 2 edge select
      if (mc_en && (ext23_rising[0] ? rise[2] : fall[2])) begin
        ext_irq_flags[2] <= 1'b1;
      end else if (clr[3]) begin
        ext_irq_flags[2] <= 1'b0;
      end
      // ext 3 chooses its edge, 4..6 rise; a match also requests
      for (int k = 0; k < 4; k++) begin
        if ((mc_en && ((k == 0 && !ext23_rising[1]) ? fall[3+k]
                                                    : rise[3+k]))
            || cmp_hit[k]) begin
          ext_irq_flags[3+k] <= 1'b1;
        end else if (clr[2*k+5]) begin
          ext_irq_flags[3+k] <= 1'b0;
        end
      end
    end
  end

  // reload trigger flag, cleared by software only
  // falling edge sets flag
  always_ff @(posedge clk) begin
    if (rst) begin
      timer2_reload_pin_flag <= 1'b0;
    end else if (mc_en && fall[7]) begin
      timer2_reload_pin_flag <= 1'b1;
    end else if (reload_flag_clr) begin
      timer2_reload_pin_flag <= 1'b0;
    end
  end

  // shared serial and timer 2 vectors
  assign pend = {ext_irq_flags[6],
                 timer2_overflow_flag || timer2_reload_pin_flag,
                 ext_irq_flags[5], uart_receive_done || uart_transmit_done,
                 ext_irq_flags[4], timer1_overflow_flag,
                 ext_irq_flags[3], ext_irq_flags[1],
                 ext_irq_flags[2], timer0_overflow_flag,
                 converter_done_flag, ext_irq_flags[0]};

  always_comb begin
    for (int p = 0; p < irq_unit_pkg::NUM_PAIRS; p++) begin
      en_vec[2*p]   = irq_enable_reg_lo[irq_unit_pkg::EN_ALL_BIT]
                      && irq_enable_reg_lo[p];
      en_vec[2*p+1] = irq_enable_reg_lo[irq_unit_pkg::EN_ALL_BIT]
                      && irq_enable_reg_hi[p];
    end
  end

  // highest level currently in service
  always_comb begin
    top_lvl = 2'd0;
    for (int l = 0; l < 4; l++) begin
      if (in_service[l]) top_lvl = 2'(l);
    end
  end

  // level first, then fixed polling order
  always_comb begin
    logic [1:0] lvl;
    lvl       = 2'd0;
    win_valid = 1'b0;
    win_idx   = 4'd0;
    win_lvl   = 2'd0;
    for (int l = 3; l >= 0; l--) begin
      for (int s = 0; s < irq_unit_pkg::NUM_SRC; s++) begin
        lvl = {prio_level_reg_hi[s/2], prio_level_reg_lo[s/2]};
        if (!win_valid && pend[s] && en_vec[s] && lvl == 2'(l) &&
            (in_service == 4'h0 || lvl > top_lvl)) begin
          win_valid = 1'b1;
          win_idx   = 4'(s);
          win_lvl   = lvl;
        end
      end
    end
  end

  // request register, refreshed once per machine cycle
  // one machine cycle to present
  always_ff @(posedge clk) begin
    if (rst || take) begin
      irq_req <= '0;
      req_idx <= 4'd0;
    end else if (mc_en) begin
      irq_req.valid  <= win_valid;
      irq_req.level  <= win_lvl;
      irq_req.vector <= (win_idx[0] ? irq_unit_pkg::VEC_BASE_HI
                                    : irq_unit_pkg::VEC_BASE_LO)
                        + irq_unit_pkg::VEC_STEP * 16'(win_idx[3:1]);
      req_idx        <= win_idx;
    end
  end

  assign clr = take ? (12'h001 << req_idx) : 12'h000;

  always_ff @(posedge clk) begin
    taken_src <= rst ? 12'h000 : clr;
  end

  // in-service levels; return frees the top level first
  always_ff @(posedge clk) begin
    if (rst) begin
      in_service <= 4'h0;
    end else begin
      for (int l = 0; l < 4; l++) begin
        if (take && irq_req.level == 2'(l)) begin
          in_service[l] <= 1'b1;
        end else if (cpu_reti && top_lvl == 2'(l)) begin
          in_service[l] <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_vector_set: assert property (
    irq_req.valid |-> irq_req.vector[2:0] == 3'h3 &&
      irq_req.vector <= 16'h006b && irq_req.vector != 16'h0033 &&
      irq_req.vector != 16'h003b) else $error("bad vector");
  chk_serial_cause: assert property (
    $rose(irq_req.valid) && irq_req.vector == irq_unit_pkg::VEC_SERIAL
    |-> $past(uart_receive_done) || $past(uart_transmit_done))
    else $error("serial vector without cause");
  // decode the vector back to its enable bit, from the registers
  chk_enable_gate: assert property (
    $rose(irq_req.valid) |->
      $past(irq_enable_reg_lo[irq_unit_pkg::EN_ALL_BIT]) &&
      ((((irq_req.vector[6] ? $past(irq_enable_reg_hi)
                            : $past(irq_enable_reg_lo))
         >> irq_req.vector[5:3]) & 8'h01) == 8'h01))
    else $error("disabled vector taken");
  chk_req_latency: assert property (
    (win_valid && !irq_req.valid && !cpu_ack) [*2]
    |-> ##[0:req_bound] irq_req.valid) else $error("request too slow");
  chk_level_follow: assert property (
    mc_en && !ext01_edge_mode[0] |=> ext_irq_flags[0] != $past(pin_q[0]))
    else $error("level flag not following pin");
  chk_edge_select: assert property (
    mc_en && ext23_rising[0] && rise[2] |=> ext_irq_flags[2])
    else $error("rising edge missed");
  chk_match_request: assert property (
    cmp_hit[0] |=> ext_irq_flags[3] && !cmp_cap_pin_oe_n[0])
    else $error("match without request");
  chk_mode0_clear: assert property (
    timer2_ovf_pulse && !cmp_hit[0] && cmp_cfg[0].mode ==
    irq_unit_pkg::CMP_SET_ON_MATCH |=> !cmp_cap_pin_out[0])
    else $error("overflow did not clear output");
  chk_mode1_hold: assert property (
    timer2_ovf_pulse && !cmp_hit[1] && cmp_cfg[1].mode ==
    irq_unit_pkg::CMP_SOFT_LEVEL |=> $stable(cmp_cap_pin_out[1]))
    else $error("overflow changed output");
  chk_preempt_level: assert property (
    $rose(irq_req.valid) |-> in_service == 4'h0 ||
      irq_req.level > top_lvl) else $error("no preemption right");
  chk_edge_clear: assert property (
    take && req_idx == 4'd3 && !(mc_en && (rise[2] || fall[2]))
    |=> !ext_irq_flags[2] && taken_src[3])
    else $error("edge flag not cleared");
  chk_reload_set: assert property (
    mc_en && fall[7] |=> timer2_reload_pin_flag [*1])
    else $error("reload flag missed");

  cov_preempt: cover property (take ##[1:200] take && in_service != 4'h0);
  cov_serial: cover property (take && irq_req.vector ==
                              irq_unit_pkg::VEC_SERIAL);
  cov_timer2: cover property (take && irq_req.vector ==
                              irq_unit_pkg::VEC_TIMER2);
endmodule

// file: verif/cpu_partner.sv
// cpu-side partner model: takes presented requests after a set gap
`timescale 1ns/1ps
module cpu_partner (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire irq_unit_pkg::irq_req_s irq_req,
  input  wire logic                   ack_on,
  input  wire logic [3:0]             ack_gap,
  output logic                        cpu_ack,
  output logic [15:0]                 last_vec,
  output int                          n_taken
);
  logic [3:0] wait_cnt; // cycles the current request has stood

  // ack is a one-cycle pulse launched off the falling edge; a slow cpu
  // is modelled by a larger gap, and a dropped request restarts the wait
  always @(negedge clk) begin
    if (rst || !ack_on || irq_req.valid !== 1'b1 || cpu_ack) begin
      cpu_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= ack_gap) begin
      cpu_ack  <= 1'b1;
      wait_cnt <= 4'h0;
    end else begin
      cpu_ack  <= 1'b0;
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // the vector is taken at the very edge that samples the ack
  always @(posedge clk) begin
    if (rst) begin
      n_taken <= 0;
    end else if (cpu_ack && irq_req.valid) begin
      last_vec <= irq_req.vector;
      n_taken  <= n_taken + 1;
    end
  end
endmodule

// file: verif/tb_top.sv
// self-checking bench for the multi-level interrupt unit
`timescale 1ns/1ps
module tb_top;
  localparam int MCK = 2; // short machine cycle keeps the run brief
  logic                         clk;     // 40 MHz clock
  logic                         rst;     // sync reset, active high
  logic [7:0]                   pins;    // ext 0..2, port 1 bits, reload
  logic                         wr_en;
  logic [7:0]                   wa;
  logic [7:0]                   wd;
  logic [1:0]                   e01;     // ext 0/1 edge select
  logic [1:0]                   e23;     // ext 2/3 rising select
  irq_unit_pkg::cmp_cfg_s [3:0] cfg;
  logic [15:0]                  cnt;     // timer 2 count
  logic                         ovf, tf0, tf1, rx, tx, tf2, adc;
  logic                         rld_clr, reti, ack_on;
  logic [3:0]                   ack_gap;
  wire  [3:0]                   p1_wire; // resolved port 1 levels
  wire  [3:0]                   ccout, ccoe;
  irq_unit_pkg::irq_req_s       req;
  wire  [3:0]                   isv;
  wire  [6:0]                   xf;
  wire                          rfl, ack;
  wire  [7:0]                   enl, enh, pl, ph;
  logic [15:0]                  lv;
  wire  [11:0]                  tsrc;     // taken-source pulse
  logic [11:0]                  last_src; // last non-zero pulse seen
  int                           nt, mismatches, comparisons;

  always #12.5 clk = ~clk;
  // a driven compare pin wins over the pull-up level the bench offers
  assign p1_wire = (ccoe & pins[6:3]) | (~ccoe & ccout);

  multi_level_interrupt_unit #(.MC_CLKS(MCK)) DUT (
    .clk(clk), .rst(rst), .ext_irq_pin_0(pins[0]),
    .ext_irq_pin_1(pins[1]), .ext_irq_pin_2(pins[2]),
    .cmp_cap_pin_in(p1_wire), .timer2_reload_trigger_pin(pins[7]),
    .cmp_cap_pin_out(ccout), .cmp_cap_pin_oe_n(ccoe),
    .reg_wr_en(wr_en), .reg_wr_addr(wa), .reg_wdata(wd),
    .ext01_edge_mode(e01), .ext23_rising(e23), .cmp_cfg(cfg),
    .timer2_count(cnt), .timer2_ovf_pulse(ovf),
    .timer0_overflow_flag(tf0), .timer1_overflow_flag(tf1),
    .uart_receive_done(rx), .uart_transmit_done(tx),
    .timer2_overflow_flag(tf2), .converter_done_flag(adc),
    .reload_flag_clr(rld_clr), .cpu_ack(ack), .cpu_reti(reti),
    .irq_req(req), .taken_src(tsrc), .in_service(isv),
    .ext_irq_flags(xf), .timer2_reload_pin_flag(rfl),
    .irq_enable_reg_lo(enl), .irq_enable_reg_hi(enh),
    .prio_level_reg_lo(pl), .prio_level_reg_hi(ph));

  cpu_partner partner (
    .clk(clk), .rst(rst), .irq_req(req), .ack_on(ack_on),
    .ack_gap(ack_gap), .cpu_ack(ack), .last_vec(lv), .n_taken(nt));

  // remember the last taken-source pulse, sampled mid-cycle
  always @(negedge clk) begin
    if (tsrc != 12'h000) begin
      last_src <= tsrc;
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one comparison kind: a value up to 16 bits
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // write strobe then one idle cycle, so back-to-back calls stay clean
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    wa = a;
    wd = d;
    cyc(1);
    wr_en = 1'b0;
    cyc(1);
  endtask

  task automatic en(input logic [7:0] lo, input logic [7:0] hi);
    wr(irq_unit_pkg::ADDR_EN_LO, lo);
    wr(irq_unit_pkg::ADDR_EN_HI, hi);
  endtask

  task automatic pri(input logic [7:0] lo, input logic [7:0] hi);
    wr(irq_unit_pkg::ADDR_PRIO_LO, lo);
    wr(irq_unit_pkg::ADDR_PRIO_HI, hi);
  endtask

  task automatic ret();
    reti = 1'b1;
    cyc(1);
    reti = 1'b0;
    cyc(1);
  endtask

  // low pulse longer than a machine cycle, so sampling cannot miss it
  task automatic pls(input int k);
    pins[k] = 1'b0;
    cyc(3 * MCK);
    pins[k] = 1'b1;
    cyc(3 * MCK);
  endtask

  // wait, bounded, for the partner to take one more vector
  task automatic take(input int n0, input logic [15:0] exp);
    int t;
    t = 0;
    while (nt == n0 && t < 60) begin
      cyc(1);
      t++;
    end
    chk(16'(nt != n0), 16'h1); // taken within the bound
    chk(lv, exp); // vector of the source
  endtask

  task automatic zeros();
    chk({enl, enh}, 16'h0); // cleared enables
    chk({pl, ph}, 16'h0); // cleared levels
    chk({req.valid, ccoe}, 16'h0f); // idle outputs
  endtask

  task automatic regs();
    zeros();
    wr(irq_unit_pkg::ADDR_PRIO_HI, 8'hff);
    chk(ph, 16'h3f); // top bits stay clear
    wr(8'haa, 8'hff);
    chk({enl, enh}, 16'h0); // unmapped write ignored
    en(8'h5a, 8'ha5);
    pri(8'h3c, 8'h0f);
    chk({enl, enh}, 16'h5aa5); // enables kept
    chk({pl, ph}, 16'h3c0f); // levels kept
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    zeros();
  endtask

  task automatic raise(input int s);
    case (s)
      0: pls(0);
      1: adc = 1'b1;
      2: tf0 = 1'b1;
      3: pls(2);
      4: pls(1);
      5: pls(3);
      6: tf1 = 1'b1;
      7: pls(4);
      8: rx = 1'b1;
      9: pls(5);
      10: tf2 = 1'b1;
      11: pls(6);
      12: tx = 1'b1;
      default: pls(7);
    endcase
  endtask

  // every source alone, plus the second cause of serial and timer 2
  task automatic vectors();
    int p;
    int m;
    int n0;
    ack_on = 1'b1;
    for (int s = 0; s < 14; s++) begin
      p = (s < 12) ? s / 2 : s - 8;
      m = (s < 12) ? s % 2 : 0;
      en(8'h80 | (m ? 8'h00 : 8'h01 << p), m ? 8'h01 << p : 8'h00);
      n0 = nt;
      raise(s);
      take(n0, (m ? 16'h0043 : 16'h0003) + 16'(8 * p));
      chk(16'(rfl), 16'(s == 13)); // reload pin flag
      {adc, tf0, tf1, rx, tx, tf2} = '0;
      rld_clr = 1'b1;
      cyc(1);
      rld_clr = 1'b0;
      ret();
      chk({rfl, xf}, 16'h0); // edge flags cleared
      chk(16'(last_src), 16'(12'h001 << (2 * p + m))); // source
    end
  endtask

  task automatic gating();
    int n0;
    int lat;
    n0 = nt;
    tf0 = 1'b1;
    en(8'h02, 8'h00);
    cyc(10 * MCK);
    en(8'h80, 8'h00);
    cyc(10 * MCK);
    chk(16'(nt - n0), 16'h0); // no vectoring while gated
    ack_on = 1'b0;
    en(8'h82, 8'h00);
    lat = 4;
    while (req.valid !== 1'b1 && lat < 40) begin
      cyc(1);
      lat++;
    end
    chk(16'(lat < irq_unit_pkg::LAT_MAX_MC * MCK), 16'h1); // prompt
    ack_on = 1'b1;
    take(n0, 16'h000b);
    tf0 = 1'b0;
    ret();
  endtask

  task automatic prio();
    int n0;
    ack_on = 1'b0;
    en(8'h8a, 8'h01);
    adc = 1'b1;
    tf0 = 1'b1;
    cyc(3 * MCK);
    chk(req.vector, 16'h0043); // tie goes by poll order
    n0 = nt;
    ack_on = 1'b1;
    take(n0, 16'h0043);
    adc = 1'b0;
    ack_on = 1'b0; // hold off so the pair is taken at its final level
    pri(8'h02, 8'h02);
    cyc(MCK);
    chk(16'(req.level), 16'h3); // level from both bits
    ack_on = 1'b1;
    take(n0 + 1, 16'h000b); // higher pair level preempts
    tf0 = 1'b0;
    chk(isv, 16'h9); // both levels held
    tf1 = 1'b1;
    ret();
    cyc(8 * MCK);
    chk(16'(nt - n0), 16'h2); // same level must wait
    ret();
    take(n0 + 2, 16'h001b);
    tf1 = 1'b0;
    ret();
    pri(8'h00, 8'h00);
  endtask

  task automatic edges();
    int n0;
    e01 = 2'b00;
    e23 = 2'b11;
    {pins[0], pins[2], pins[3]} = 3'b000;
    cyc(4 * MCK);
    chk(xf[3:0], 16'h1); // low level, no rising yet
    {pins[0], pins[2], pins[3]} = 3'b111;
    cyc(4 * MCK);
    chk(xf[3:0], 16'hc); // level follows pin
    e01 = 2'b01;
    pls(0);
    chk(xf[3:0], 16'hd); // falling edge held
    n0 = nt;
    en(8'h81, 8'h06);
    repeat (3) begin
      cyc(8 * MCK);
      ret();
    end
    chk({12'(nt - n0), xf[3:0]}, 16'h0030); // taken
    en(8'h00, 8'h00);
    e23 = 2'b00;
  endtask

  task automatic compare();
    cfg[0] = {1'b1, irq_unit_pkg::CMP_SET_ON_MATCH, 1'b0, 16'h1234};
    cfg[1] = {1'b1, irq_unit_pkg::CMP_SOFT_LEVEL, 1'b1, 16'h1234};
    cyc(2);
    chk(ccoe, 16'hc); // channels drive port 1
    cnt = 16'h1234;
    cyc(2);
    cnt = 16'h0000;
    cyc(1);
    chk({ccout, 2'b00, xf[4:3]}, 16'h33); // output and request
    ovf = 1'b1;
    cyc(1);
    ovf = 1'b0;
    cyc(1);
    chk(ccout, 16'h2); // overflow clears mode 0 only
    cfg[1].soft_level = 1'b0;
    cnt = 16'h1234;
    cyc(2);
    cnt = 16'h0000;
    cyc(1);
    chk(ccout, 16'h1); // chosen low level
    cfg = '0;
    cyc(2);
    chk(ccoe, 16'hf); // pins released
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    pins = 8'hff;
    {wr_en, ovf, tf0, tf1, rx, tx, tf2, adc, rld_clr, reti} = '0;
    {wa, wd, cnt, e23, ack_on} = '0;
    e01 = 2'b11;
    cfg = '0;
    ack_gap = 4'h1;
    mismatches = 0;
    comparisons = 0;
    cyc(16);
    rst = 1'b0;
    cyc(1);
    regs();
    vectors();
    gating();
    prio();
    edges();
    compare();
    tally_and_finish();
  end

  // watchdog: the full sequence needs a few thousand clocks at most
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
